// [core/vic_regs.svh]
// Purpose: register offsets, field positions, reset values for the interrupt controller
// Assumes: apb, 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef VIC_REGS_SVH
`define VIC_REGS_SVH

`define VIC_OFF_CTRL0     12'h000
`define VIC_OFF_CTRL1     12'h004
`define VIC_OFF_CTRL2     12'h008
`define VIC_OFF_GRP0      12'h00c
`define VIC_OFF_GRP1      12'h010
`define VIC_OFF_GRP2      12'h014
`define VIC_OFF_GRP3      12'h018
`define VIC_OFF_EDGE      12'h01c
`define VIC_OFF_STACK     12'h020
`define VIC_OFF_STATUS    12'h024

`define VIC_RST_BYTE      8'h00
`define VIC_MASK_CTRL0    8'h7f
`define VIC_MASK_FULL     8'hff
`define VIC_MASK_GRP0     8'h33
`define VIC_MASK_GRP2     8'h77
`define VIC_MASK_EDGE     8'h0f

`define VIC_BIT_GIE       0
`define VIC_EDGE_OFF      2'b00
`define VIC_EDGE_RISE     2'b01
`define VIC_EDGE_FALL     2'b10
`define VIC_EDGE_BOTH     2'b11

`define VIC_NUM_SRC       9
`define VIC_NUM_MEMBERS   20
`define VIC_STACK_DEPTH   8

`endif

// [core/vic_pkg.sv]
// Purpose: types for the interrupt controller
// Assumes: nothing
// Notes: source index order is also the fixed priority, 0 highest
package vic_pkg;
	typedef logic [7:0] vic_byte_t;
	typedef logic [3:0] vic_src_t;
	typedef enum logic [2:0]
	{
		VIC_IDLE  = 3'b001,
		VIC_TAKE  = 3'b010,
		VIC_WAIT  = 3'b100
	} vic_state_e;
endpackage : vic_pkg

// [core/vic_edge_sync.sv]
// Purpose: synchronise one external pin and detect the selected edge
// Assumes: pin is asynchronous to SYS_CLK
// Notes: a change counts once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
`include "vic_regs.svh"
module vic_edge_sync
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// pin and control
	input  wire logic       pin,
	input  wire logic       route_en,
	input  wire logic [1:0] edge_sel,
	// event
	output logic            hit
);
	logic [2:0] sync_ff;
	logic       level_ff;
	logic       agree;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sync_ff <= 3'h0;
		else
			sync_ff <= {sync_ff[1:0], pin};
	end

	// first stage is read only by the second stage
	assign agree = (sync_ff[1] == sync_ff[2]);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			level_ff <= 1'b0;
		else if (agree)
			level_ff <= sync_ff[2];
	end

	always_comb
	begin
		hit = 1'b0;
		if (route_en && agree && (sync_ff[2] != level_ff))
		begin
			case (edge_sel) // R14
				`VIC_EDGE_RISE: hit = sync_ff[2];
				`VIC_EDGE_FALL: hit = ~sync_ff[2];
				`VIC_EDGE_BOTH: hit = 1'b1;
				default:        hit = 1'b0;
			endcase
		end
	end
endmodule : vic_edge_sync
`default_nettype wire

// [core/vic_top.sv]
// Purpose: vectored interrupt controller with apb register file
// Assumes: core raises INSN_BOUNDARY between instructions, acks each vector
// Notes: priority is source index order, lowest index wins
//
// Contract
// R01: source events always set their request flag
// R02: disabled flags stay latched, never vector
// R03: global enable low suppresses every interrupt
// R04: push return address, then load vector
// R05: return instruction pops the saved address
// R06: servicing clears the global enable
// R07: requests during service still latch flags
// R08: software re-enables global for nesting
// R09: full stack blocks all acknowledgement
// R10: one request chosen by fixed priority
// R11: any set flag wakes from sleep
// R12: pre-set flag avoids unwanted wake-up; code raises WAKE_UP on every set event, flag pre-set or not
// R13: pin flag set on selected edge
// R14: edge select off, rise, fall, both
// R15: pin active only when enabled and routed
// R16: pin service clears its own flag
// R17: groups share one vector per group
// R18: enabled member flag sets group flag
// R19: group service leaves member flags set
// R20: control 0 layout, global at bit 0
// R21: control 1 layout, converter at bit 7
// R22: control 2 layout, group 3 at bit 7
// R23: each member has flag and enable
// R24: one means pending or enabled, unused zero
// R25: flags writable, all reset to zero
// R26: present at boundary, clear with vector load
`timescale 1ns/1ps
`default_nettype none
`include "vic_regs.svh"
module vic_top
#(
	parameter int STACK_DEPTH = `VIC_STACK_DEPTH
)
(
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RESET_N,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// external pins and pin-sharing routes
	input  wire logic        EXT_IRQ_PIN0,
	input  wire logic        EXT_IRQ_PIN1,
	input  wire logic [1:0]  PIN_ROUTE_IRQ,
	// internal event pulses
	input  wire logic        TOUCH_EVENT,
	input  wire logic        SERIAL_PORT_EVENT,
	input  wire logic        CONVERTER_DONE_EVENT,
	input  wire logic [1:0]  TIMEBASE_EVENT,
	input  wire logic [`VIC_NUM_MEMBERS-1:0] MEMBER_EVENT,
	// core sequencer
	input  wire logic        INSN_BOUNDARY,
	input  wire logic        VECTOR_ACK,
	input  wire logic        RETURN_FROM_INTERRUPT,
	input  wire logic        STACK_POP_SW,
	output logic             IRQ_REQ,
	output vic_pkg::vic_src_t IRQ_VECTOR,
	output logic             STACK_PUSH,
	output logic             STACK_POP,
	output logic             WAKE_UP
);
	import vic_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// register state
	vic_byte_t  ctrl0_ff, ctrl1_ff, ctrl2_ff;
	vic_byte_t  grp_ff [4];
	logic [3:0] edge_ff;
	logic [$clog2(STACK_DEPTH+1)-1:0] sp_ff;
	vic_state_e state_ff;
	vic_src_t   vec_ff;
	logic       stack_full;

	// apb decode
	logic       wr_en, rd_en;
	logic [11:0] addr;
	assign addr  = PADDR;
	assign wr_en = PSEL && PENABLE && PWRITE && PREADY;
	assign rd_en = PSEL && !PENABLE && !PWRITE;

	function automatic logic hit_addr(input logic [11:0] a, input logic [11:0] off);
		hit_addr = (a == off);
	endfunction : hit_addr

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a <= `VIC_OFF_STATUS) && (a[1:0] == 2'b00);
	endfunction : is_mapped

	////////////////////////////////////////////////////////////////////////////
	// pins
	logic [1:0] pin_hit;
	logic [1:0] pins;
	assign pins = {EXT_IRQ_PIN1, EXT_IRQ_PIN0};

	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++)
		begin : g_pin
			vic_edge_sync u_sync
			(
				.clk      (SYS_CLK),
				.rst_n    (RESET_N),
				.pin      (pins[gp]),
				.route_en (ctrl0_ff[1+gp] && PIN_ROUTE_IRQ[gp]), // R15
				.edge_sel (edge_ff[2*gp +: 2]),                  // R13
				.hit      (pin_hit[gp])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// group member flags: byte layout per group, flags high nibble, enables low
	// member events map onto the flag positions in order
	logic [3:0] grp_evt [4];
	logic [3:0] grp_set;
	always_comb
	begin
		grp_evt[0] = {2'b00, MEMBER_EVENT[1:0]};
		grp_evt[1] = MEMBER_EVENT[5:2];
		grp_evt[2] = {1'b0, MEMBER_EVENT[8:6]};
		grp_evt[3] = {2'b00, MEMBER_EVENT[10:9]};
	end

	function automatic vic_byte_t grp_mask(input int g);
		case (g)
			0:       grp_mask = `VIC_MASK_GRP0;
			2:       grp_mask = `VIC_MASK_GRP2;
			3:       grp_mask = `VIC_MASK_GRP0;
			default: grp_mask = `VIC_MASK_FULL;
		endcase
	endfunction : grp_mask

	genvar gg;
	generate
		for (gg = 0; gg < 4; gg++)
		begin : g_grp
			// enabled member raising its flag sets the group flag
			assign grp_set[gg] = |(grp_evt[gg] & grp_ff[gg][3:0]); // R18

			always_ff @(posedge SYS_CLK)
			begin
				if (!RESET_N)
					grp_ff[gg] <= `VIC_RST_BYTE; // R25
				else if (wr_en && hit_addr(addr, 12'(`VIC_OFF_GRP0 + 4*gg)))
					grp_ff[gg] <= (PWDATA[7:0] | {grp_evt[gg], 4'h0}) & grp_mask(gg); // R01 R23
				else
					grp_ff[gg] <= (grp_ff[gg] | {grp_evt[gg], 4'h0}) & grp_mask(gg); // R19
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// primary sources, index = priority
	// pending: 0 pin0 1 pin1 2 touch 3 serial 4 grp0 5 grp1 6 conv 7 grp2 8 tb0 9 tb1 (grp3 via bit 10)
	logic [10:0] pend_flag, pend_en;
	assign pend_flag = {ctrl2_ff[7], ctrl2_ff[6], ctrl2_ff[5], ctrl2_ff[4], ctrl1_ff[7],
		ctrl1_ff[6], ctrl1_ff[5], ctrl1_ff[4], ctrl0_ff[6], ctrl0_ff[5], ctrl0_ff[4]};
	assign pend_en = {ctrl2_ff[3], ctrl2_ff[2], ctrl2_ff[1], ctrl2_ff[0], ctrl1_ff[3],
		ctrl1_ff[2], ctrl1_ff[1], ctrl1_ff[0], ctrl0_ff[3], ctrl0_ff[2], ctrl0_ff[1]};

	logic [10:0] active;
	logic        any_active;
	vic_src_t    pick;
	assign active     = pend_flag & pend_en; // R02
	assign any_active = |active;

	always_comb
	begin
		pick = 4'h0;
		for (int i = 10; i >= 0; i--) // R10
			if (active[i])
				pick = 4'(i);
	end

	// serviced-flag clear masks, bit position in each control byte
	logic [7:0] clr0, clr1, clr2;
	always_comb
	begin
		clr0 = 8'h00;
		clr1 = 8'h00;
		clr2 = 8'h00;
		if (state_ff == VIC_TAKE && VECTOR_ACK)
		begin
			clr0[`VIC_BIT_GIE] = 1'b1; // R06
			case (vec_ff) // R16 R26
				4'h0: clr0[4] = 1'b1;
				4'h1: clr0[5] = 1'b1;
				4'h2: clr0[6] = 1'b1;
				4'h3: clr1[4] = 1'b1;
				4'h4: clr1[5] = 1'b1;
				4'h5: clr1[6] = 1'b1;
				4'h6: clr1[7] = 1'b1;
				4'h7: clr2[4] = 1'b1;
				4'h8: clr2[5] = 1'b1;
				4'h9: clr2[6] = 1'b1;
				4'ha: clr2[7] = 1'b1;
				default: clr0[`VIC_BIT_GIE] = 1'b1;
			endcase
		end
	end

	// event set masks; set wins over any clear
	logic [7:0] set0, set1, set2;
	assign set0 = {1'b0, TOUCH_EVENT, pin_hit, 4'h0}; // R01 R07
	assign set1 = {CONVERTER_DONE_EVENT, grp_set[1], grp_set[0], SERIAL_PORT_EVENT, 4'h0};
	assign set2 = {grp_set[3], TIMEBASE_EVENT[1], TIMEBASE_EVENT[0], grp_set[2], 4'h0};

	function automatic vic_byte_t upd(input vic_byte_t cur, input logic we, input vic_byte_t wd,
		input vic_byte_t clr, input vic_byte_t set, input vic_byte_t msk);
		vic_byte_t base;
		base = we ? wd : (cur & ~clr);
		upd  = (base | set) & msk;
	endfunction : upd

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			ctrl0_ff <= `VIC_RST_BYTE; // R25
			ctrl1_ff <= `VIC_RST_BYTE;
			ctrl2_ff <= `VIC_RST_BYTE;
		end
		else
		begin
			ctrl0_ff <= upd(ctrl0_ff, wr_en && hit_addr(addr, `VIC_OFF_CTRL0), PWDATA[7:0], clr0, set0,
				`VIC_MASK_CTRL0); // R20 R24
			ctrl1_ff <= upd(ctrl1_ff, wr_en && hit_addr(addr, `VIC_OFF_CTRL1), PWDATA[7:0], clr1, set1,
				`VIC_MASK_FULL); // R21
			ctrl2_ff <= upd(ctrl2_ff, wr_en && hit_addr(addr, `VIC_OFF_CTRL2), PWDATA[7:0], clr2, set2,
				`VIC_MASK_FULL); // R22
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
			edge_ff <= 4'h0;
		else if (wr_en && hit_addr(addr, `VIC_OFF_EDGE))
			edge_ff <= PWDATA[3:0]; // R14
	end

	////////////////////////////////////////////////////////////////////////////
	// return stack depth tracking
	assign stack_full = (sp_ff == ($clog2(STACK_DEPTH+1))'(STACK_DEPTH));

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
			sp_ff <= '0;
		else if (wr_en && hit_addr(addr, `VIC_OFF_STACK))
			sp_ff <= PWDATA[$clog2(STACK_DEPTH+1)-1:0];
		else if (state_ff == VIC_TAKE && VECTOR_ACK)
			sp_ff <= sp_ff + 1'b1; // R04
		else if ((RETURN_FROM_INTERRUPT || STACK_POP_SW) && sp_ff != '0)
			sp_ff <= sp_ff - 1'b1; // R05 R09
	end

	////////////////////////////////////////////////////////////////////////////
	// request sequencer
	logic take_ok;
	assign take_ok = ctrl0_ff[`VIC_BIT_GIE] && any_active && !stack_full && INSN_BOUNDARY; // R03 R09 R26

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			state_ff <= VIC_IDLE;
			vec_ff   <= 4'h0;
		end
		else
		begin
			case (state_ff)
				VIC_IDLE:
				begin
					if (take_ok)
					begin
						state_ff <= VIC_TAKE;
						vec_ff   <= pick; // R10 R17
					end
				end
				VIC_TAKE:
					if (VECTOR_ACK)
						state_ff <= VIC_WAIT;
				VIC_WAIT:
					state_ff <= VIC_IDLE;
				default:
					state_ff <= VIC_IDLE;
			endcase
		end
	end

	// outputs, all registered
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			IRQ_REQ    <= 1'b0;
			IRQ_VECTOR <= 4'h0;
			STACK_PUSH <= 1'b0;
			STACK_POP  <= 1'b0;
			WAKE_UP    <= 1'b0;
		end
		else
		begin
			IRQ_REQ    <= (state_ff == VIC_IDLE) && take_ok;
			IRQ_VECTOR <= (state_ff == VIC_IDLE && take_ok) ? pick : IRQ_VECTOR;
			STACK_PUSH <= (state_ff == VIC_TAKE) && VECTOR_ACK; // R04
			STACK_POP  <= RETURN_FROM_INTERRUPT && (sp_ff != '0); // R05
			WAKE_UP    <= |{set0, set1, set2}; // R11
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// apb read path; zero-wait, ready in the cycle after each setup
	vic_byte_t rd_byte;
	always_comb
	begin
		rd_byte = 8'h00;
		case (addr)
			`VIC_OFF_CTRL0:  rd_byte = ctrl0_ff;
			`VIC_OFF_CTRL1:  rd_byte = ctrl1_ff;
			`VIC_OFF_CTRL2:  rd_byte = ctrl2_ff;
			`VIC_OFF_GRP0:   rd_byte = grp_ff[0];
			`VIC_OFF_GRP1:   rd_byte = grp_ff[1];
			`VIC_OFF_GRP2:   rd_byte = grp_ff[2];
			`VIC_OFF_GRP3:   rd_byte = grp_ff[3];
			`VIC_OFF_EDGE:   rd_byte = {4'h0, edge_ff};
			`VIC_OFF_STACK:  rd_byte = 8'(sp_ff);
			`VIC_OFF_STATUS: rd_byte = {stack_full, state_ff, vec_ff};
			default:         rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET_N)
		begin
			PRDATA  <= 32'h0;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PREADY  <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !is_mapped(addr);
			if (rd_en)
				PRDATA <= {24'h0, rd_byte};
		end
	end
endmodule : vic_top
`default_nettype wire

// [bench/vic_core_model.sv]
// Purpose: core sequencer stand-in for the interrupt controller
// Assumes: one-cycle vector acknowledge
// Notes: slow adds two cycles before acknowledging
`timescale 1ns/1ps
`default_nettype none
module vic_core_model
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// controller side
	input  wire logic irq_req,
	input  wire logic slow,
	input  wire logic stall,
	output logic      boundary,
	output logic      ack
);
	logic [2:0] dly_ff;
	// a stalled pipeline never reaches a boundary
	assign boundary = !stall;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			dly_ff <= 3'h0;
		else
			dly_ff <= {dly_ff[1:0], irq_req};
	end
	// pc pushed and vector loaded on ack
	assign ack = slow ? dly_ff[2] : dly_ff[0];
endmodule : vic_core_model
`default_nettype wire

// [bench/vic_top_properties.sv]
// Purpose: port-level checks for the interrupt controller
// Assumes: one clock, synchronous reset
// Notes: bound to every vic_top instance
`timescale 1ns/1ps
`default_nettype none
module vic_top_properties
(
	// clock and reset
	input wire logic              SYS_CLK,
	input wire logic              RESET_N,
	// apb
	input wire logic              PSEL,
	input wire logic              PENABLE,
	input wire logic              PREADY,
	input wire logic              PSLVERR,
	input wire logic [31:0]       PRDATA,
	// events and core
	input wire logic              TOUCH_EVENT,
	input wire logic              SERIAL_PORT_EVENT,
	input wire logic              INSN_BOUNDARY,
	input wire logic              VECTOR_ACK,
	input wire logic              RETURN_FROM_INTERRUPT,
	input wire logic              IRQ_REQ,
	input wire vic_pkg::vic_src_t IRQ_VECTOR,
	input wire logic              STACK_PUSH,
	input wire logic              STACK_POP,
	input wire logic              WAKE_UP
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	////////////////////////////////////////////////////////////////
	a_ready_setup: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("no ready after setup");
	a_err_ready: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	a_rdata_unused: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
		else $error("upper read bits set");
	a_req_single: assert property (IRQ_REQ |=> !IRQ_REQ [*2])
		else $error("request longer than one cycle");
	a_req_boundary: assert property (IRQ_REQ |-> $past(INSN_BOUNDARY))
		else $error("request off boundary");
	a_vector_range: assert property (IRQ_REQ |-> IRQ_VECTOR <= 4'ha)
		else $error("vector out of range");
	a_vector_held: assert property (!IRQ_REQ |-> $stable(IRQ_VECTOR))
		else $error("vector moved without take");
	a_push_ack: assert property (VECTOR_ACK |=> STACK_PUSH)
		else $error("no push after ack");
	a_pop_return: assert property (RETURN_FROM_INTERRUPT |=> STACK_POP)
		else $error("no pop after return");
	a_wake_event: assert property (TOUCH_EVENT || SERIAL_PORT_EVENT |=> WAKE_UP)
		else $error("no wake after event");
	c_pin_take: cover property (IRQ_REQ && IRQ_VECTOR == 4'h0);
	c_pop: cover property (STACK_POP);
	c_refused: cover property (PSLVERR);
endmodule : vic_top_properties
bind vic_top vic_top_properties u_props (.SYS_CLK, .RESET_N, .PSEL, .PENABLE, .PREADY, .PSLVERR,
	.PRDATA, .TOUCH_EVENT, .SERIAL_PORT_EVENT, .INSN_BOUNDARY, .VECTOR_ACK, .RETURN_FROM_INTERRUPT,
	.IRQ_REQ, .IRQ_VECTOR, .STACK_PUSH, .STACK_POP, .WAKE_UP);
`default_nettype wire

// [bench/vectored_interrupt_controller_tb.sv]
// Purpose: self-checking bench for the interrupt controller
// Assumes: apb answers with one access cycle
// Notes: core side is vic_core_model
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller_tb;
	import vic_pkg::*;
	logic        clk, rst_n, psel, pen, pwr, pready, perr, err, p0, p1;
	logic        tch, ser, cnv, irq, push, pop, wake, ret, slow, stall, ack, bnd;
	logic [11:0] pa;
	logic [31:0] pwd, prd, rd;
	logic [1:0]  route;
	logic [19:0] mem;
	vic_src_t    vec;
	int          num_errors = 0;
	int          num_checks = 0;
	vic_top u_dut (.SYS_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
		.PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(perr), .EXT_IRQ_PIN0(p0), .EXT_IRQ_PIN1(p1),
		.PIN_ROUTE_IRQ(route), .TOUCH_EVENT(tch), .SERIAL_PORT_EVENT(ser), .CONVERTER_DONE_EVENT(cnv),
		.TIMEBASE_EVENT(2'h0), .MEMBER_EVENT(mem), .INSN_BOUNDARY(bnd), .VECTOR_ACK(ack),
		.RETURN_FROM_INTERRUPT(ret), .STACK_POP_SW(1'b0), .IRQ_REQ(irq), .IRQ_VECTOR(vec),
		.STACK_PUSH(push), .STACK_POP(pop), .WAKE_UP(wake));
	vic_core_model u_core (.clk(clk), .rst_n(rst_n), .irq_req(irq), .slow(slow), .stall(stall),
		.boundary(bnd), .ack(ack));
	////////////////////////////////////////////////////////////////
	task summarize;
		if (num_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// pready sampled before the edge's own updates land
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int i;
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= {24'h0, d};
		@(posedge clk);
		pen <= 1;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (pready !== 1'b1);
		chk("pready", 1, pready);
		rd = prd;
		err = perr;
		psel <= 0;
		pen <= 0;
	endtask : apb
	task fire(input logic t, input logic s, input logic c, input logic [19:0] m);
		@(posedge clk);
		{tch, ser, cnv, mem} <= {t, s, c, m};
		@(posedge clk);
		{tch, ser, cnv, mem} <= '0;
	endtask : fire
	task take(input logic [3:0] v);
		int i;
		for (i = 0; irq !== 1'b1 && i < 20; i++)
		begin
			@(posedge clk);
			#1;
		end
		chk("vector", {27'h0, 1'b1, v}, {27'h0, irq, vec});
		repeat (6) @(posedge clk);
	endtask : take
	task none(input int n);
		int c;
		c = 0;
		repeat (n)
		begin
			@(posedge clk);
			#1;
			c += irq;
		end
		chk("idle", 0, c);
	endtask : none
	task edge_chk(input logic lvl, input logic e);
		@(posedge clk);
		p0 <= lvl;
		repeat (8) @(posedge clk);
		apb(0, 0, 0);
		chk("pin flag", {27'h0, e, 4'h2}, rd);
		apb(1, 0, 8'h02);
	endtask : edge_chk
	////////////////////////////////////////////////////////////////
	task t_regs;
		logic [7:0] m [8] = '{8'h7e, 8'hfe, 8'hfe, 8'h32, 8'hfe, 8'h76, 8'h32, 8'h0e};
		for (int k = 0; k < 8; k++)
		begin
			apb(0, 12'(4 * k), 0);
			chk("reset", 0, rd);
			apb(1, 12'(4 * k), 8'hfe);
			apb(0, 12'(4 * k), 0);
			chk("rw", {24'h0, m[k]}, rd);
			apb(1, 12'(4 * k), 0);
		end
		apb(0, 12'h040, 0);
		chk("unmapped", 1, err);
	endtask : t_regs
	task t_gate;
		apb(1, 0, 8'h01);
		fire(1, 0, 0, 0);
		#1;
		chk("wake", 1, wake);
		none(8);
		apb(0, 0, 0);
		chk("latched", 8'h41, rd);
		apb(1, 0, 8'h48);
		none(8);
		apb(1, 0, 8'h49);
		take(2);
		apb(0, 0, 0);
		chk("auto clear", 8'h08, rd);
	endtask : t_gate
	// slow ack here so VIC_TAKE is held waiting for the ack
	task t_prio;
		slow <= 1;
		apb(1, 12'h004, 8'h09);
		fire(0, 1, 1, 0);
		apb(1, 0, 8'h01);
		take(3);
		apb(0, 12'h004, 0);
		chk("left", 8'h89, rd);
		apb(1, 0, 8'h01);
		take(6);
		apb(1, 12'h004, 0);
		slow <= 0;
	endtask : t_prio
	task t_group;
		apb(1, 12'h00c, 8'h01);
		apb(1, 12'h004, 8'h02);
		fire(0, 0, 0, 20'h2);
		apb(0, 12'h004, 0);
		chk("group idle", 8'h02, rd);
		fire(0, 0, 0, 20'h1);
		apb(1, 0, 8'h01);
		take(4);
		apb(0, 12'h00c, 0);
		chk("members", 8'h31, rd);
		apb(0, 12'h004, 0);
		chk("group clear", 8'h02, rd);
		apb(1, 12'h00c, 0);
	endtask : t_group
	task t_pins;
		route <= 2'h1;
		apb(1, 0, 8'h02);
		for (int k = 0; k < 4; k++)
		begin
			apb(1, 12'h01c, 8'(k));
			edge_chk(1, k[0]);
			edge_chk(0, k[1]);
		end
		route <= 2'h0;
		edge_chk(1, 0);
		route <= 2'h1;
		apb(1, 0, 8'h03);
		@(posedge clk);
		p0 <= 0;
		take(0);
		apb(0, 0, 0);
		chk("pin clear", 8'h02, rd);
	endtask : t_pins
	task t_stack;
		apb(1, 12'h020, 8'h08);
		apb(1, 0, 8'h09);
		fire(1, 0, 0, 0);
		none(8);
		stall <= 1;
		@(posedge clk);
		ret <= 1;
		@(posedge clk);
		ret <= 0;
		none(8);
		stall <= 0;
		take(2);
		apb(0, 12'h020, 0);
		chk("depth", 8, rd);
	endtask : t_stack
	////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		{rst_n, psel, pen, pwr, p0, p1, tch, ser, cnv, ret, slow, stall} = '0;
		{pa, pwd, route, mem} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1;
		t_regs;
		t_gate;
		t_prio;
		t_group;
		t_pins;
		t_stack;
		summarize;
	end
	// the whole run needs well under a fifth of this
	initial
	begin
		#100us;
		num_errors++;
		summarize;
	end
endmodule : vectored_interrupt_controller_tb
`default_nettype wire
